/* qeiirq_top.sv */
// Encoder interrupt enable, raw status and masked status registers
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ns
module qeiirq_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        index_pin,
  input  wire logic        phase_error_event,
  input  wire logic        direction_change_event,
  input  wire logic        timer_expiry_event,
  input  wire logic [31:0] measured_velocity,
  output logic             irq
);
  qeiirq_pkg::qeiirq_state_type st_r;
  qeiirq_pkg::qeiirq_state_type st_nxt;

  logic       idx_q2;
  logic       idx_q3;
  logic       index_pulse_event;
  logic [3:0] ev_set;
  logic [3:0] clr;
  logic [3:0] masked;
  logic       take;

  qeiirq_sync u_idx_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  (index_pin),
    .q2      (idx_q2),
    .q3      (idx_q3)
  );

  // Rising edge only once stages two and three agree high
  assign index_pulse_event = idx_q2 & idx_q3 & ~st_r.idx_q3_r
                             & st_r.idx_q2_r;

  assign ev_set[qeiirq_pkg::QEIIRQ_BIT_INDEX] = index_pulse_event;
  assign ev_set[qeiirq_pkg::QEIIRQ_BIT_TIMER] = timer_expiry_event;
  assign ev_set[qeiirq_pkg::QEIIRQ_BIT_DIR]   = direction_change_event;
  assign ev_set[qeiirq_pkg::QEIIRQ_BIT_ERROR] = phase_error_event;

  // Write to masked register clears matching raw bits
  assign clr = (st_r.wr_pend_r &&
                st_r.addr_r == qeiirq_pkg::QEIIRQ_OFS_MASKED)
               ? hwdata[3:0] : 4'h0;

  assign masked = st_r.raw_r & st_r.enable_r;
  assign irq = |masked;

  assign take = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata_r;

  always_comb begin
    st_nxt = st_r;
    st_nxt.idx_q2_r = idx_q2;
    st_nxt.idx_q3_r = idx_q3;
    // Set wins so a coincident event is never lost
    st_nxt.raw_r = (st_r.raw_r & ~clr) | ev_set;
    if (st_r.wr_pend_r &&
        st_r.addr_r == qeiirq_pkg::QEIIRQ_OFS_ENABLE) begin
      st_nxt.enable_r = hwdata[3:0];
    end
    // Raw register has no write path at all
    st_nxt.wr_pend_r = take & hwrite;
    st_nxt.rd_pend_r = take & ~hwrite;
    if (take) begin
      st_nxt.addr_r = haddr[11:0];
    end
    // Read data prepared in the address phase, held until next read
    if (take && !hwrite) begin
      case (haddr[11:0])
        qeiirq_pkg::QEIIRQ_OFS_ENABLE: begin
          st_nxt.rdata_r = {28'h0000000, st_r.enable_r};
        end
        qeiirq_pkg::QEIIRQ_OFS_RAW: begin
          st_nxt.rdata_r = {28'h0000000, st_r.raw_r};
        end
        qeiirq_pkg::QEIIRQ_OFS_MASKED: begin
          st_nxt.rdata_r = {28'h0000000, masked};
        end
        qeiirq_pkg::QEIIRQ_OFS_VELO: begin
          st_nxt.rdata_r = measured_velocity;
        end
        default: begin
          st_nxt.rdata_r = qeiirq_pkg::QEIIRQ_RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.enable_r  <= qeiirq_pkg::QEIIRQ_RST_BITS;
      st_r.raw_r     <= qeiirq_pkg::QEIIRQ_RST_BITS;
      st_r.idx_q2_r  <= 1'b0;
      st_r.idx_q3_r  <= 1'b0;
      st_r.wr_pend_r <= 1'b0;
      st_r.rd_pend_r <= 1'b0;
      st_r.addr_r    <= 12'h000;
      st_r.rdata_r   <= qeiirq_pkg::QEIIRQ_RST_WORD;
    end else begin
      st_r <= st_nxt;
    end
  end

  chk_irq_masked_or: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq == |(st_r.raw_r & st_r.enable_r))
    else $error("irq not OR of masked bits");

  chk_raw_latch_event: assert property (
    @(posedge hclk) disable iff (!hresetn)
    phase_error_event |=> st_r.raw_r[3])
    else $error("phase error not latched");

  chk_raw_sticky_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_r.raw_r[2] && clr[2] == 1'b0) |=> st_r.raw_r[2])
    else $error("raw bit dropped without clear");

  chk_clear_w1c_raw: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clr[1] && !timer_expiry_event) |=> !st_r.raw_r[1])
    else $error("one write did not clear bit");

  chk_set_beats_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clr[2] && direction_change_event) |=> st_r.raw_r[2])
    else $error("set lost to clear");

  chk_index_clear_raw: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (clr[0] && !index_pulse_event) |=> !st_r.raw_r[0])
    else $error("index raw not cleared");

  chk_index_pin_sets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(idx_q3) && idx_q2 |=> st_r.raw_r[0])
    else $error("index pulse not latched");

  chk_index_masked_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_r.enable_r == 4'h0) |-> !irq)
    else $error("irq while all masked");

  chk_enable_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (take && hwrite && haddr[11:0] == qeiirq_pkg::QEIIRQ_OFS_ENABLE)
    ##1 1'b1 |=> st_r.enable_r == $past(hwdata[3:0]))
    else $error("enable write not stored");

  cov_index_irq: cover property (
    @(posedge hclk) disable iff (!hresetn) irq && st_r.raw_r[0]);
  cov_set_clear_same: cover property (
    @(posedge hclk) disable iff (!hresetn) clr[3] && phase_error_event);
  cov_masked_raw: cover property (
    @(posedge hclk) disable iff (!hresetn) st_r.raw_r[1] && !irq);
endmodule

/* qeiirq_pkg.sv */
// Constants and types for the encoder interrupt status block
//
// Overview of operation
// - Enable bits 3..0, upper bits read zero
// - Request only when enable and raw set
// - Raw bits latch regardless of enable mask
// - Raw zero means no event since clear
// - Index pulse detection sets raw bit 0
// - Index request only while index enabled
// - Masked bit is raw AND enable
// - Masked register shows sources now requesting
// - Write one clears event; zero ignored
// - Clearing masked index also clears raw index
// - Raw read-only; cleared via masked write
package qeiirq_pkg;
  localparam int unsigned QEIIRQ_NSRC = 4;
  localparam logic [11:0] QEIIRQ_OFS_ENABLE = 12'h020;
  localparam logic [11:0] QEIIRQ_OFS_RAW    = 12'h024;
  localparam logic [11:0] QEIIRQ_OFS_MASKED = 12'h028;
  localparam logic [11:0] QEIIRQ_OFS_VELO   = 12'h01C;
  localparam int unsigned QEIIRQ_BIT_INDEX  = 0;
  localparam int unsigned QEIIRQ_BIT_TIMER  = 1;
  localparam int unsigned QEIIRQ_BIT_DIR    = 2;
  localparam int unsigned QEIIRQ_BIT_ERROR  = 3;
  localparam logic [3:0]  QEIIRQ_RST_BITS   = 4'h0;
  localparam logic [31:0] QEIIRQ_RST_WORD   = 32'h00000000;
  localparam logic [1:0]  QEIIRQ_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  QEIIRQ_HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic [3:0]  enable_r;
    logic [3:0]  raw_r;
    logic        idx_q2_r;
    logic        idx_q3_r;
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [11:0] addr_r;
    logic [31:0] rdata_r;
  } qeiirq_state_type;
endpackage

/* qeiirq_sync.sv */
// Three-stage pin synchroniser for the index input
`timescale 1ns/1ns
module qeiirq_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_in,
  output logic      q2,
  output logic      q3
);
  logic q1;

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q1 <= 1'b0;
      q2 <= 1'b0;
      q3 <= 1'b0;
    end else begin
      q1 <= pin_in;
      q2 <= q1;
      q3 <= q2;
    end
  end
endmodule

/* qeiirq_far.sv */
// Encoder core stand-in that raises events on command
`timescale 1ns/1ns
module qeiirq_far (
  input  wire logic       hclk,
  input  wire logic [3:0] fire,
  output logic            index_pin,
  output logic            phase_error_event,
  output logic            direction_change_event,
  output logic            timer_expiry_event
);
  logic [2:0] idx_cnt = 3'h0;
  // Index held high for four cycles so the synchroniser cannot miss it
  // Plain always keeps the power-up value legal without a reset pin
  always @(posedge hclk) begin
    if (fire[0]) begin
      idx_cnt <= 3'h4;
    end else if (idx_cnt != 3'h0) begin
      idx_cnt <= idx_cnt - 3'h1;
    end
  end
  assign index_pin              = (idx_cnt != 3'h0);
  assign timer_expiry_event     = fire[1];
  assign direction_change_event = fire[2];
  assign phase_error_event      = fire[3];
endmodule

/* qeiirq_bench.sv */
// Register-level bench for the encoder interrupt block
`timescale 1ns/1ns
module qeiirq_bench;
  localparam logic [11:0] EN = qeiirq_pkg::QEIIRQ_OFS_ENABLE;
  localparam logic [11:0] RW = qeiirq_pkg::QEIIRQ_OFS_RAW;
  localparam logic [11:0] MS = qeiirq_pkg::QEIIRQ_OFS_MASKED;
  logic        hclk    = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel    = 1'h0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [3:0]  fire    = 4'h0;
  logic [31:0] velo    = 32'h1234ABCD;
  logic        hready, hresp, ip, pe, dc, te, irq;
  logic [31:0] hrdata;
  int          err_count = 0;
  int          checked   = 0;
  always #20 hclk = ~hclk;
  qeiirq_far i_qeiirq_far (.hclk(hclk), .fire(fire), .index_pin(ip),
    .phase_error_event(pe), .direction_change_event(dc),
    .timer_expiry_event(te));
  qeiirq_top i_qeiirq_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .index_pin(ip), .phase_error_event(pe),
    .direction_change_event(dc), .timer_expiry_event(te),
    .measured_velocity(velo), .irq(irq));
  task automatic tally_and_finish();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded so a stuck slave ends the run instead of hanging it
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'h1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // Events fired in the data phase land on the same edge as the write, except index, which lands four edges later
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] f);
    hwrite <= 1'h1;
    haddr  <= {20'h0, a};
    htrans <= qeiirq_pkg::QEIIRQ_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    fire   <= f;
    wait_rdy();
    fire   <= 4'h0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    hwrite <= 1'h0;
    haddr  <= {20'h0, a};
    htrans <= qeiirq_pkg::QEIIRQ_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    cmp(hrdata, e);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    hsel    <= 1'h1;
    cmp({31'h0, irq}, 32'h0);
    cmp({31'h0, hresp}, 32'h0);
    rdc(EN, 32'h0);
    rdc(RW, 32'h0);
    rdc(MS, 32'h0);
    wr(EN, 32'hFFFFFFFF, 4'h0);
    rdc(EN, 32'hF);
    wr(EN, 32'h0, 4'hF);
    repeat (8) @(posedge hclk);
    rdc(RW, 32'hF);
    rdc(MS, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    wr(RW, 32'h0, 4'h0);
    rdc(RW, 32'hF);
    for (int i = 0; i < 4; i++) begin
      wr(EN, 32'h1 << i, 4'h0);
      rdc(MS, 32'h1 << i);
      cmp({31'h0, irq}, 32'h1);
      wr(MS, 32'h0, 4'h0);
      rdc(MS, 32'h1 << i);
      wr(MS, 32'h1 << i, 4'h0);
      rdc(RW, (32'hF >> (i + 1)) << (i + 1));
      cmp({31'h0, irq}, 32'h0);
    end
    wr(EN, 32'hF, 4'h0);
    wr(MS, 32'h8, 4'h8);
    rdc(RW, 32'h8);
    cmp({31'h0, irq}, 32'h1);
    cmp({31'h0, hresp}, 32'h0);
    rdc(qeiirq_pkg::QEIIRQ_OFS_VELO, 32'h1234ABCD);
    rdc(12'h030, 32'h0);
    tally_and_finish();
  end
endmodule
